// [mio_pkg.sv]
// Shared constants and types for the memory-mapped port bus peripheral
package mio_pkg;

	// ------------------------------------------------------------
	// Basic types
	// ------------------------------------------------------------
	typedef logic [7:0] mio_byte_t; // One bus byte

	// Bus pins after the two-flop synchroniser
	typedef struct packed {
		logic periph_rst_n; // Peripheral reset line, low active
		logic low_range_qualifier; // Address within the low 256
		logic read_strobe; // Processor read level
		logic write_strobe; // Processor write level
		mio_byte_t address_lines; // Line zero is the LSB
		mio_byte_t data_lines; // Shared data lines, as seen
	} mio_bus_s;

	localparam int MIO_SYNC_W = $bits(mio_bus_s);

	// Transfer state of the stall handshake
	typedef enum logic [1:0] {
		MIO_IDLE,
		MIO_RD_WAIT,
		MIO_WR_WAIT
	} mio_state_e;

	// ------------------------------------------------------------
	// Port addresses inside the processor memory space
	// ------------------------------------------------------------
	localparam mio_byte_t MIO_READER_CHAR_ADDR = 8'h20;
	localparam mio_byte_t MIO_READER_STATUS_ADDR = 8'h21;
	localparam mio_byte_t MIO_PUNCH_CHAR_ADDR = 8'h22;
	localparam mio_byte_t MIO_PUNCH_STATUS_ADDR = 8'h23;

	// ------------------------------------------------------------
	// Status field positions and reset values
	// ------------------------------------------------------------
	localparam int MIO_CHAR_READY_FLAG_BIT = 7;
	localparam int MIO_IRQ_ENABLE_RESERVED_BIT = 6;
	localparam int MIO_FAULT_FLAG_BIT = 5;
	localparam int MIO_FETCH_ONE_CHAR_BIT = 0;
	localparam mio_byte_t MIO_BYTE_RST = 8'h00;
	localparam logic [MIO_SYNC_W-1:0] MIO_SYNC_RST = '0;

endpackage : mio_pkg

// [mio_sync.sv]
// Two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ns
module mio_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ------------------------------------------------------------
	// Per-bit stage pair; first stage feeds only the second
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta; // Metastable stage, read by stage two only
			always_ff @(posedge ref_clk or posedge sys_rst) begin
				if (sys_rst) begin
					meta <= RST_VAL[i];
					sync_out[i] <= RST_VAL[i];
				end else if (clk_en) begin
					meta <= async_in[i];
					sync_out[i] <= meta;
				end
			end
		end
	endgenerate

endmodule : mio_sync

// [mio_port_bus.sv]
// Reader and punch ports on the memory-mapped peripheral bus
`timescale 1ns/1ns
// Functional notes
// - Ports live in ordinary memory address space
// - Reading output-only port returns zero
// - Increment on output port writes one
// - Bus lines driven open-collector, wired-OR
// - Address lines active high, line zero LSB
// - Decode includes low-range qualifier line
// - Port select low while address decoded
// - Slow port pulls stall line low
// - Peripheral reset line restores start-up state
// - Punch write stalls while still punching
// - Reader read fetches, stalls until ready
// - Service request pulls interrupt line low
// - Status ports separate from data ports
// - Reader has data port plus status port
// - Ready flag set on char, cleared on access
// - Writing fetch bit reads one character
// - Fault flag on error; bit six reserved
// - Punch data write-only; status shows readiness
module mio_port_bus (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic stall_mode,
	input wire mio_pkg::mio_byte_t address_lines,
	input wire logic low_range_qualifier,
	input wire logic read_strobe,
	input wire logic write_strobe,
	input wire logic periph_rst_n,
	input wire mio_pkg::mio_byte_t data_in,
	output mio_pkg::mio_byte_t data_out,
	output mio_pkg::mio_byte_t data_oe,
	output logic stall_n_out,
	output logic stall_n_oe,
	output logic port_select_n_out,
	output logic port_select_n_oe,
	output logic irq_n_out,
	output logic irq_n_oe,
	output logic reader_fetch,
	input wire mio_pkg::mio_byte_t reader_char,
	input wire logic reader_char_valid,
	input wire logic reader_fault,
	output logic punch_strobe,
	output mio_pkg::mio_byte_t punch_char,
	input wire logic punch_busy,
	input wire logic punch_fault
);
	import mio_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	mio_bus_s bus; // Synchronised bus pins
	logic rd_d; // Read level one cycle back
	logic wr_d; // Write level one cycle back
	logic rd_start; // Rising read strobe
	logic wr_start; // Rising write strobe
	logic loc_rst; // Synchronous peripheral reset
	logic hit_rc; // Reader char port decoded
	logic hit_rs; // Reader status port decoded
	logic hit_pc; // Punch char port decoded
	logic hit_ps; // Punch status port decoded
	logic any_hit; // Any of our four ports
	mio_state_e state; // Stall handshake state
	mio_byte_t char_hold; // Received character
	logic char_ready; // Character waiting
	logic rd_fault; // Sticky reader error
	logic rd_irq_en; // Reader interrupt enable
	logic pn_irq_en; // Punch interrupt enable
	logic pn_fault; // Registered punch error
	logic fetch_req; // Fetch one character now
	logic punch_go; // Fire the punch now
	mio_byte_t next_rd_data; // Read mux result

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	// Strobes, address and data come from another timing world
	mio_sync #(
		.WIDTH(MIO_SYNC_W),
		.RST_VAL(MIO_SYNC_RST)
	) u_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in({periph_rst_n, low_range_qualifier, read_strobe, write_strobe, address_lines, data_in}),
		.sync_out(bus)
	);

	// ------------------------------------------------------------
	// Address decode and strobe edges
	// ------------------------------------------------------------
	// Plain memory addresses, gated by the low-range line
	assign hit_rc = bus.low_range_qualifier && (bus.address_lines == MIO_READER_CHAR_ADDR);
	assign hit_rs = bus.low_range_qualifier && (bus.address_lines == MIO_READER_STATUS_ADDR);
	assign hit_pc = bus.low_range_qualifier && (bus.address_lines == MIO_PUNCH_CHAR_ADDR);
	assign hit_ps = bus.low_range_qualifier && (bus.address_lines == MIO_PUNCH_STATUS_ADDR);
	assign any_hit = hit_rc | hit_rs | hit_pc | hit_ps;
	assign rd_start = bus.read_strobe & ~rd_d;
	assign wr_start = bus.write_strobe & ~wr_d;
	// Bus reset line acts as a synchronous clear
	assign loc_rst = ~bus.periph_rst_n;

	// Edge history for the strobes
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_d <= 1'b0;
			wr_d <= 1'b0;
		end else if (clk_en) begin
			rd_d <= bus.read_strobe;
			wr_d <= bus.write_strobe;
		end
	end

	// ------------------------------------------------------------
	// Stall handshake
	// ------------------------------------------------------------
	// Only the stall scheme ever leaves idle; polling never stalls
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= MIO_IDLE;
		end else if (clk_en) begin
			if (loc_rst) begin
				state <= MIO_IDLE;
			end else begin
				unique case (state)
					MIO_IDLE: begin
						if (stall_mode && rd_start && hit_rc) begin
							state <= MIO_RD_WAIT;
						end else if (stall_mode && wr_start && hit_pc && punch_busy) begin
							state <= MIO_WR_WAIT;
						end
					end
					MIO_RD_WAIT: begin
						// Released the cycle the character lands
						if (reader_char_valid) begin
							state <= MIO_IDLE;
						end
					end
					MIO_WR_WAIT: begin
						// Held data goes out once the punch frees up
						if (!punch_busy) begin
							state <= MIO_IDLE;
						end
					end
				endcase
			end
		end
	end

	// Stall and select pulled low only, never driven high
	assign stall_n_out = 1'b0;
	assign stall_n_oe = (state != MIO_IDLE);
	assign port_select_n_out = 1'b0;
	assign port_select_n_oe = any_hit;

	// ------------------------------------------------------------
	// Reader side
	// ------------------------------------------------------------
	// Fetch bit write, or a stalling read of the char port
	assign fetch_req = (wr_start && hit_rs && bus.data_lines[MIO_FETCH_ONE_CHAR_BIT])
		|| (stall_mode && rd_start && hit_rc && (state == MIO_IDLE));

	// One-cycle fetch pulse to the tape mechanism
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reader_fetch <= 1'b0;
		end else if (clk_en) begin
			reader_fetch <= fetch_req && !loc_rst;
		end
	end

	// Character capture and ready flag; arrival beats the clearing access
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			char_hold <= MIO_BYTE_RST;
			char_ready <= 1'b0;
		end else if (clk_en) begin
			if (loc_rst) begin
				char_hold <= MIO_BYTE_RST;
				char_ready <= 1'b0;
			end else if (reader_char_valid) begin
				char_hold <= reader_char;
				// A stalled read consumes the character at once
				char_ready <= (state != MIO_RD_WAIT);
			end else if ((rd_start || wr_start) && hit_rc) begin
				char_ready <= 1'b0;
			end
		end
	end

	// Sticky reader error, cleared by the next fetch unless a new one lands
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_fault <= 1'b0;
		end else if (clk_en) begin
			if (loc_rst) begin
				rd_fault <= 1'b0;
			end else if (reader_fault) begin
				rd_fault <= 1'b1;
			end else if (fetch_req) begin
				rd_fault <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Status enables (the reserved interrupt enable bit)
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_irq_en <= 1'b0;
			pn_irq_en <= 1'b0;
		end else if (clk_en) begin
			if (loc_rst) begin
				rd_irq_en <= 1'b0;
				pn_irq_en <= 1'b0;
			end else if (wr_start && hit_rs) begin
				rd_irq_en <= bus.data_lines[MIO_IRQ_ENABLE_RESERVED_BIT];
			end else if (wr_start && hit_ps) begin
				pn_irq_en <= bus.data_lines[MIO_IRQ_ENABLE_RESERVED_BIT];
			end
		end
	end

	// Service request pulls the shared interrupt line low
	assign irq_n_out = 1'b0;
	assign irq_n_oe = (rd_irq_en && char_ready) || (pn_irq_en && !punch_busy);

	// ------------------------------------------------------------
	// Punch side
	// ------------------------------------------------------------
	// Busy write without stall scheme is dropped; software should poll first
	assign punch_go = (wr_start && hit_pc && !punch_busy) || ((state == MIO_WR_WAIT) && !punch_busy);

	// Character latched on the write edge; a non-busy write fires the punch on that same edge
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			punch_char <= MIO_BYTE_RST;
			punch_strobe <= 1'b0;
		end else if (clk_en) begin
			if (loc_rst) begin
				punch_char <= MIO_BYTE_RST;
				punch_strobe <= 1'b0;
			end else begin
				if (wr_start && hit_pc) begin
					punch_char <= bus.data_lines;
				end
				punch_strobe <= punch_go;
			end
		end
	end

	// Punch error level, registered for the status port
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pn_fault <= 1'b0;
		end else if (clk_en) begin
			pn_fault <= punch_fault && !loc_rst;
		end
	end

	// ------------------------------------------------------------
	// Read data path
	// ------------------------------------------------------------
	// Punch char port is write-only and therefore reads zero
	always_comb begin
		next_rd_data = MIO_BYTE_RST;
		if (bus.read_strobe && !loc_rst) begin
			if (hit_rc) begin
				if (state == MIO_RD_WAIT) begin
					// Zero until the fetched character arrives
					next_rd_data = reader_char_valid ? reader_char : MIO_BYTE_RST;
				end else begin
					next_rd_data = char_hold;
				end
			end else if (hit_rs) begin
				next_rd_data[MIO_CHAR_READY_FLAG_BIT] = char_ready;
				next_rd_data[MIO_IRQ_ENABLE_RESERVED_BIT] = rd_irq_en;
				next_rd_data[MIO_FAULT_FLAG_BIT] = rd_fault;
			end else if (hit_ps) begin
				next_rd_data[MIO_CHAR_READY_FLAG_BIT] = !punch_busy;
				next_rd_data[MIO_IRQ_ENABLE_RESERVED_BIT] = pn_irq_en;
				next_rd_data[MIO_FAULT_FLAG_BIT] = pn_fault;
			end
		end
	end

	// Registered data; zero during a stall, then the delivered char is kept
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_out <= MIO_BYTE_RST;
		end else if (clk_en) begin
			if ((state == MIO_RD_WAIT) && !reader_char_valid && !loc_rst) begin
				data_out <= MIO_BYTE_RST;
			end else begin
				data_out <= next_rd_data;
			end
		end
	end

	// Open-collector data: only the one bits pull the wired-OR
	assign data_oe = data_out;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst || !clk_en || loc_rst);

	sequence s_stall_read;
		stall_mode && rd_start && hit_rc && (state == MIO_IDLE);
	endsequence

	sequence s_char_lands;
		(state == MIO_RD_WAIT) && reader_char_valid;
	endsequence

	out_port_zero_a: assert property (bus.read_strobe && hit_pc ##1 bus.read_strobe |-> data_out == 8'h00)
		else $error("output-only port did not read zero");
	inc_writes_one_a: assert property (wr_start && hit_pc && !punch_busy && bus.data_lines == 8'h01
		|=> punch_char == 8'h01 && punch_strobe)
		else $error("write to punch port not captured and fired");
	// Ports form one aligned block of four, so the upper six lines name the block
	select_hold_a: assert property (bus.low_range_qualifier
		&& bus.address_lines[7:2] == MIO_READER_CHAR_ADDR[7:2] |-> port_select_n_oe && !port_select_n_out)
		else $error("port select not held during decoded address");
	select_qual_a: assert property (!bus.low_range_qualifier |-> !port_select_n_oe)
		else $error("port select without low-range qualifier");
	punch_release_a: assert property (state == MIO_WR_WAIT && !punch_busy |=> !stall_n_oe && punch_strobe)
		else $error("held punch write not fired on release");
	read_stall_a: assert property (s_stall_read |=> stall_n_oe && reader_fetch ##1 !reader_fetch)
		else $error("stalling read did not fetch and stall");
	read_release_a: assert property (s_char_lands |=> !stall_n_oe && data_out == $past(reader_char))
		else $error("stall release without delivered character");
	punch_stall_a: assert property (stall_mode && wr_start && hit_pc && punch_busy && state == MIO_IDLE
		|=> stall_n_oe && !punch_strobe)
		else $error("busy punch write did not stall");
	ready_flag_a: assert property (reader_char_valid && state != MIO_RD_WAIT |=> char_ready)
		else $error("ready flag not set on arrival");
	fetch_once_a: assert property (wr_start && hit_rs && bus.data_lines[0] |=> reader_fetch ##1 !reader_fetch)
		else $error("fetch bit did not give one pulse");
	fault_sticky_a: assert property (reader_fault |=> rd_fault)
		else $error("reader fault not flagged");
	irq_pull_a: assert property (rd_irq_en && char_ready |-> irq_n_oe && !irq_n_out)
		else $error("interrupt line not pulled on ready char");
	bus_release_a: assert property (!bus.read_strobe ##1 !bus.read_strobe |-> data_oe == 8'h00)
		else $error("data lines driven outside a read");

endmodule : mio_port_bus

// [mio_cpu_model.sv]
// Processor-side model of the shared port bus: address, strobes, data, peripheral reset
`timescale 1ns/1ns
module mio_cpu_model #(
	parameter int HOLD_CYC = 125, // 0.5 us of strobe at 4 ns
	parameter int RST_CYC = 50 // Shortened power-up pulse, keeps the run short
) (
	input wire logic ref_clk,
	output mio_pkg::mio_byte_t address_lines,
	output logic low_range_qualifier,
	output logic read_strobe,
	output logic write_strobe,
	output logic periph_rst_n,
	output mio_pkg::mio_byte_t data_in,
	input wire mio_pkg::mio_byte_t data_out,
	input wire mio_pkg::mio_byte_t data_oe,
	input wire logic stall_line_n,
	input wire logic select_line_n
);
	import mio_pkg::*;
	mio_byte_t cpu_drive; // Own data, zero once released
	// Wired-OR of every party pulling a data line
	assign data_in = cpu_drive | (data_out & data_oe);
	// Idle address 0xFF decodes to no port
	initial begin
		address_lines = 8'hFF;
		low_range_qualifier = 1'b1;
		read_strobe = 1'b0;
		write_strobe = 1'b0;
		periph_rst_n = 1'b1;
		cpu_drive = 8'h00;
	end
	// One ordinary memory transfer
	task automatic xfer(input logic wr, input mio_byte_t addr, input logic qual, input mio_byte_t wdata,
		output mio_byte_t rdata, output logic sel, output logic stalled, output logic timeout);
		int n;
		stalled = 1'b0;
		n = 0;
		@(posedge ref_clk);
		#1;
		address_lines = addr; // Active high, line zero LSB
		low_range_qualifier = qual; // Low-range flag
		cpu_drive = wr ? wdata : 8'h00;
		repeat (2) @(posedge ref_clk);
		#1;
		// Strobe only after address and data settle
		if (wr) begin
			write_strobe = 1'b1;
		end else begin
			read_strobe = 1'b1;
		end
		repeat (HOLD_CYC) begin
			@(posedge ref_clk);
			#1;
			stalled |= !stall_line_n;
		end
		// Stay in the transfer while a port holds the stall line
		while (!stall_line_n && n < 4000) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		timeout = !stall_line_n;
		rdata = data_in;
		sel = !select_line_n;
		read_strobe = 1'b0;
		write_strobe = 1'b0;
		// Address and data outlive the strobe through the synchroniser
		repeat (3) @(posedge ref_clk);
		#1;
		cpu_drive = 8'h00;
		address_lines = 8'hFF;
		low_range_qualifier = 1'b1;
	endtask : xfer
	// Peripheral reset pulse
	task automatic power_reset();
		@(posedge ref_clk);
		#1;
		periph_rst_n = 1'b0;
		repeat (RST_CYC) @(posedge ref_clk);
		#1;
		periph_rst_n = 1'b1;
	endtask : power_reset
endmodule : mio_cpu_model

// [mio_port_bus_tb.sv]
// Self-checking bench for the reader and punch ports
`timescale 1ns/1ns
module mio_port_bus_tb;
	import mio_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic stall_mode = 1'b0;
	logic reader_char_valid = 1'b0;
	logic reader_fault = 1'b0;
	logic punch_busy = 1'b0;
	logic punch_fault = 1'b0;
	mio_byte_t reader_char = 8'h00;
	mio_byte_t address_lines, data_in, data_out, data_oe, punch_char, last_char, rd, wd;
	logic low_range_qualifier, read_strobe, write_strobe, periph_rst_n, reader_fetch, punch_strobe;
	logic stall_n_out, stall_n_oe, port_select_n_out, port_select_n_oe, irq_n_out, irq_n_oe;
	logic stall_line_n, select_line_n, irq_line_n, sel, stl, to;
	mio_byte_t punched[$]; // Bytes seen by the punch mechanism
	int seed = 24, mismatches = 0, tests_run = 0, rd_cnt = 0, pb_cnt = 0, fetches = 0, i, k;
	// Pulled-up open-collector lines
	assign stall_line_n = stall_n_oe ? stall_n_out : 1'b1;
	assign select_line_n = port_select_n_oe ? port_select_n_out : 1'b1;
	assign irq_line_n = irq_n_oe ? irq_n_out : 1'b1;
	always #2 ref_clk = ~ref_clk;
	mio_port_bus u_mio_port_bus (.ref_clk, .sys_rst, .clk_en(1'b1), .stall_mode, .address_lines,
		.low_range_qualifier, .read_strobe, .write_strobe, .periph_rst_n, .data_in, .data_out, .data_oe,
		.stall_n_out, .stall_n_oe, .port_select_n_out, .port_select_n_oe, .irq_n_out, .irq_n_oe,
		.reader_fetch, .reader_char, .reader_char_valid, .reader_fault, .punch_strobe, .punch_char,
		.punch_busy, .punch_fault);
	mio_cpu_model #(.HOLD_CYC(125), .RST_CYC(50)) u_mio_cpu_model (.ref_clk, .address_lines,
		.low_range_qualifier, .read_strobe, .write_strobe, .periph_rst_n, .data_in, .data_out, .data_oe,
		.stall_line_n, .select_line_n);
	// ----------------------------------------
	// Mechanisms
	// ----------------------------------------
	// Reader answers each fetch after a random delay
	always @(posedge ref_clk) begin
		#1;
		reader_char_valid = 1'b0;
		if (reader_fetch) begin
			fetches++;
			rd_cnt = 8 + ($random(seed) & 63);
		end else if (rd_cnt == 1) begin
			reader_char = 8'($random(seed));
			last_char = reader_char;
			reader_char_valid = 1'b1;
			rd_cnt = 0;
		end else if (rd_cnt > 0) begin
			rd_cnt--;
		end
	end
	// Punch stays busy longer than one bus transfer
	always @(posedge ref_clk) begin
		#1;
		if (punch_strobe) begin
			punched.push_back(punch_char);
			punch_busy = 1'b1;
			pb_cnt = 400 + ($random(seed) & 63);
		end else if (pb_cnt > 0) begin
			pb_cnt--;
			punch_busy = (pb_cnt != 0);
		end
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic mio_byte_t status_exp(input logic ready, input logic en, input logic fault);
		status_exp = MIO_BYTE_RST;
		status_exp[MIO_CHAR_READY_FLAG_BIT] = ready;
		status_exp[MIO_IRQ_ENABLE_RESERVED_BIT] = en;
		status_exp[MIO_FAULT_FLAG_BIT] = fault;
	endfunction : status_exp
	task automatic check(input string name, input mio_byte_t seen, input mio_byte_t exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : conclude
	task automatic bus(input logic wr, input mio_byte_t a, input logic q, input mio_byte_t d);
		u_mio_cpu_model.xfer(wr, a, q, d, rd, sel, stl, to);
		if (to) begin
			mismatches++;
			$display("[FAIL] stall wait expected release seen timeout");
			conclude();
		end
	endtask : bus
	task automatic rd_chk(input string name, input mio_byte_t a, input mio_byte_t exp, input logic exp_sel);
		bus(1'b0, a, 1'b1, 8'h00);
		check(name, rd, exp);
		check({name, " select"}, {7'h00, sel}, {7'h00, exp_sel});
	endtask : rd_chk
	// Bounded wait until reader and punch are quiet
	task automatic settle();
		for (i = 0; i < 3000 && (rd_cnt != 0 || punch_busy); i++) @(posedge ref_clk);
		if (i == 3000) begin
			mismatches++;
			$display("[FAIL] mechanism wait expected idle seen busy");
			conclude();
		end
		repeat (3) @(posedge ref_clk);
	endtask : settle
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		// Both status ports and the punch char port are read and written below
		repeat (12) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1;
		check("idle data enables", data_oe, 8'h00);
		check("idle lines", {5'h00, stall_n_oe, port_select_n_oe, irq_n_oe}, 8'h00);
		rd_chk("reader status", MIO_READER_STATUS_ADDR, status_exp(1'b0, 1'b0, 1'b0), 1'b1);
		rd_chk("punch status", MIO_PUNCH_STATUS_ADDR, status_exp(1'b1, 1'b0, 1'b0), 1'b1);
		rd_chk("reversed address", 8'h04, 8'h00, 1'b0);
		rd_chk("neighbour address", 8'h24, 8'h00, 1'b0);
		bus(1'b1, MIO_READER_STATUS_ADDR, 1'b0, 8'h01);
		check("select without qualifier", {7'h00, sel}, 8'h00);
		check("fetch without qualifier", 8'(fetches), 8'h00);
		bus(1'b1, MIO_READER_STATUS_ADDR, 1'b1, 8'h41);
		settle();
		check("fetch count", 8'(fetches), 8'h01);
		rd_chk("ready status", MIO_READER_STATUS_ADDR, status_exp(1'b1, 1'b1, 1'b0), 1'b1);
		check("irq asserted", {7'h00, irq_line_n}, 8'h00);
		rd_chk("reader char", MIO_READER_CHAR_ADDR, last_char, 1'b1);
		rd_chk("ready cleared", MIO_READER_STATUS_ADDR, status_exp(1'b0, 1'b1, 1'b0), 1'b1);
		check("irq released", {7'h00, irq_line_n}, 8'h01);
		reader_fault = 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
		reader_fault = 1'b0;
		rd_chk("fault set", MIO_READER_STATUS_ADDR, status_exp(1'b0, 1'b1, 1'b1), 1'b1);
		bus(1'b1, MIO_READER_STATUS_ADDR, 1'b1, 8'h41);
		settle();
		rd_chk("fault cleared", MIO_READER_STATUS_ADDR, status_exp(1'b1, 1'b1, 1'b0), 1'b1);
		rd_chk("second char", MIO_READER_CHAR_ADDR, last_char, 1'b1);
		// Increment of an output-only port: read gives zero, write gives one
		rd_chk("punch char read", MIO_PUNCH_CHAR_ADDR, 8'h00, 1'b1);
		bus(1'b1, MIO_PUNCH_CHAR_ADDR, 1'b1, rd + 8'h01);
		punch_fault = 1'b1;
		rd_chk("punch busy", MIO_PUNCH_STATUS_ADDR, status_exp(1'b0, 1'b0, 1'b1), 1'b1);
		punch_fault = 1'b0;
		settle();
		check("increment result", punched.pop_front(), 8'h01);
		for (k = 0; k < 6; k++) begin
			wd = 8'($random(seed));
			bus(1'b1, MIO_PUNCH_CHAR_ADDR, 1'b1, wd);
			settle();
			check("punched byte", punched.pop_front(), wd);
			bus(1'b1, MIO_READER_STATUS_ADDR, 1'b1, 8'h01);
			settle();
			rd_chk("random char", MIO_READER_CHAR_ADDR, last_char, 1'b1);
		end
		stall_mode = 1'b1;
		bus(1'b0, MIO_READER_CHAR_ADDR, 1'b1, 8'h00);
		check("stalled read", rd, last_char);
		check("read stall seen", {7'h00, stl}, 8'h01);
		rd_chk("no ready after stall", MIO_READER_STATUS_ADDR, status_exp(1'b0, 1'b0, 1'b0), 1'b1);
		bus(1'b1, MIO_PUNCH_CHAR_ADDR, 1'b1, 8'hA5);
		bus(1'b1, MIO_PUNCH_CHAR_ADDR, 1'b1, 8'h5A);
		check("write stall seen", {7'h00, stl}, 8'h01);
		settle();
		check("first punched", punched.pop_front(), 8'hA5);
		check("second punched", punched.pop_front(), 8'h5A);
		stall_mode = 1'b0;
		// Punch interrupt enable: idle punch requests service
		bus(1'b1, MIO_PUNCH_STATUS_ADDR, 1'b1, 8'h40);
		check("punch irq", {7'h00, irq_line_n}, 8'h00);
		rd_chk("punch irq enable", MIO_PUNCH_STATUS_ADDR, status_exp(1'b1, 1'b1, 1'b0), 1'b1);
		// Leave a waiting character and both enables set, then reset the ports
		bus(1'b1, MIO_READER_STATUS_ADDR, 1'b1, 8'h41);
		u_mio_cpu_model.power_reset();
		repeat (4) @(posedge ref_clk);
		rd_chk("after peripheral reset", MIO_READER_STATUS_ADDR, 8'h00, 1'b1);
		rd_chk("punch after reset", MIO_PUNCH_STATUS_ADDR, status_exp(1'b1, 1'b0, 1'b0), 1'b1);
		check("irq after reset", {7'h00, irq_line_n}, 8'h01);
		conclude();
	end
endmodule : mio_port_bus_tb
